// [bench/bms_lamp_model.sv]
// Half-bridge, lamp stage and sensing networks as comparator flags
`timescale 1ns/1ps
module bms_lamp_model (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// Gates
	input  wire logic                highSideGateOut,
	input  wire logic                lowSideGateOut,
	// Levels and faults set by the bench
	input  wire bms_pkg::bms_sense_t envLevel,
	input  wire logic                ocLow,
	input  wire logic                ocHigh,
	// Flags and pulse count
	output bms_pkg::bms_sense_t      senseRaw,
	output logic [7:0]               pulseCnt
);
	import bms_pkg::*;
	logic       csPrev_ff;
	logic [7:0] pulseCnt_ff;
	// Sense resistor sees low-side current; high side only on command
	wire logic  csNow = (ocLow && lowSideGateOut) ||
		(ocHigh && highSideGateOut);
	always_comb begin
		senseRaw = envLevel;
		senseRaw.csOver = csNow;
	end
	assign pulseCnt = pulseCnt_ff;
	always_ff @(posedge clk) begin
		csPrev_ff <= csNow;
		if (reset) begin
			pulseCnt_ff <= 8'h00;
		end else if (csNow && !csPrev_ff) begin
			pulseCnt_ff <= pulseCnt_ff + 8'h01;
		end
	end
endmodule

// [bench/bms_seq_monitor.sv]
// Port checker for the ballast mode sequencer
`timescale 1ns/1ps
module bms_seq_monitor (
	// Clock and reset
	input wire logic                clk,
	input wire logic                reset,
	// APB
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [7:0]          paddr,
	input wire logic                pready,
	input wire logic                pslverr,
	// Flags and gates
	input wire bms_pkg::bms_sense_t senseRaw,
	input wire logic                boostGateReq,
	input wire logic                highSideGateOut,
	input wire logic                lowSideGateOut,
	input wire logic                boostGateOut,
	input wire logic                oscTimingNodeGround,
	input wire logic                preheatTimerNodeClear,
	input wire logic                supplyPullDown
);
	import bms_pkg::*;
	default clocking mcb @(posedge clk);
	endclocking
	default disable iff (reset);

	gate_excl_a: assert property (
		!(highSideGateOut && lowSideGateOut)) else $error("both gates on");
	quiet_stop_a: assert property (
		oscTimingNodeGround && $past(oscTimingNodeGround) |->
		!highSideGateOut && !lowSideGateOut && !boostGateOut)
		else $error("gate on while stopped");
	boost_follow_a: assert property (
		boostGateOut == (!oscTimingNodeGround && $past(boostGateReq)))
		else $error("boost gate mismatch");
	first_low_a: assert property (
		$fell(oscTimingNodeGround) |-> lowSideGateOut && !highSideGateOut)
		else $error("first pulse not low side");
	dead_gap_a: assert property (
		$fell(lowSideGateOut) || $fell(highSideGateOut) |->
		!highSideGateOut && !lowSideGateOut) else $error("no dead time");
	start_cause_a: assert property (
		$fell(oscTimingNodeGround) |-> $past(senseRaw.supplyOn, 3) &&
		!$past(senseRaw.sdAbove5v0, 3)) else $error("start without cause");
	timer_free_a: assert property (
		$fell(oscTimingNodeGround) |-> !preheatTimerNodeClear)
		else $error("timer held at start");
	trip_gates_a: assert property (
		supplyPullDown |-> !highSideGateOut && !lowSideGateOut)
		else $error("gate on in bus trip");
	trip_cause_a: assert property (
		$rose(supplyPullDown) |-> $past(senseRaw.busUnder, 3))
		else $error("pull-down without bus flag");
	supply_off_a: assert property (
		$rose(senseRaw.supplyOff) && !oscTimingNodeGround |->
		##[1:5] oscTimingNodeGround) else $error("no stop on supply off");
	apb_err_a: assert property (
		psel && penable && paddr > 8'h18 |-> pready && pslverr)
		else $error("unmapped access not refused");
endmodule

bind bms_mode_sequencer bms_seq_monitor u_mon (
	.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.paddr(paddr), .pready(pready), .pslverr(pslverr),
	.senseRaw(senseRaw), .boostGateReq(boostGateReq),
	.highSideGateOut(highSideGateOut),
	.lowSideGateOut(lowSideGateOut), .boostGateOut(boostGateOut),
	.oscTimingNodeGround(oscTimingNodeGround),
	.preheatTimerNodeClear(preheatTimerNodeClear),
	.supplyPullDown(supplyPullDown)
);

// [bench/test_ballast_mode_sequencer.sv]
// Self-checking bench for the ballast mode sequencer
`timescale 1ns/1ps
`include "bms_regs.svh"
module test_ballast_mode_sequencer;
	import bms_pkg::*;
	logic        clk, reset, psel, penable, pwrite, boostGateReq;
	logic [7:0]  paddr, pulseCnt;
	logic [31:0] pwdata, prdata, rd, rnd;
	logic        pready, pslverr, errq, hs, ls, boost, gnd, tclr, pull, irq;
	logic        ocLow, ocHigh;
	bms_sense_t  env, sense;
	int          seed, fails, numChecks, preheat_timer_node, cRun, dead, on, off, hon, i;
	int          base;

	bms_mode_sequencer #(.PREHEAT_END(32'h0000_0FFF), .SWEEP_STEP(4)) u_dut (
		.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .senseRaw(sense),
		.boostGateReq(boostGateReq), .highSideGateOut(hs),
		.lowSideGateOut(ls), .boostGateOut(boost),
		.oscTimingNodeGround(gnd), .preheatTimerNodeClear(tclr),
		.supplyPullDown(pull), .irq(irq));
	bms_lamp_model u_lamp (.clk(clk), .reset(reset),
		.highSideGateOut(hs), .lowSideGateOut(ls), .envLevel(env),
		.ocLow(ocLow), .ocHigh(ocHigh), .senseRaw(sense),
		.pulseCnt(pulseCnt));

	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		rnd = $random(seed);
		boostGateReq <= rnd[0];
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string msg);
		numChecks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t %s %0h/%0h", $time, msg, got, exp);
		end
	endtask
	task automatic stall();
		fails++;
		$display("CHECK FAILED %0t wait timed out", $time);
		conclude();
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) stall();
		rd = prdata;
		errq = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitSt(input bms_state_t s);
		int n;
		n = 0;
		do begin
			apb(1'b0, `BMS_OFS_STATUS, 32'h0);
			n++;
		end while (rd[2:0] !== s && n < 600);
		chk(rd[2:0], s, "state");
		if (rd[2:0] !== s) conclude();
	endtask
	task automatic waitLvl(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (s !== v) stall();
	endtask
	task automatic count(ref logic s, input logic v, output int c);
		c = 0;
		while (s === v && c < 4000) begin
			@(posedge clk);
			c++;
		end
	endtask
	task automatic onLen();
		waitLvl(ls, 1'b0);
		waitLvl(ls, 1'b1);
		count(ls, 1'b1, on);
		count(hs, 1'b0, off);
		count(hs, 1'b1, hon);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hb2f09b56;
		fails = 0;
		numChecks = 0;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		env = '0;
		{ocLow, ocHigh} = 2'b00;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk({hs, ls, gnd, tclr, irq}, 5'b00110, "lockout");
		preheat_timer_node = 8 + ($random(seed) & 7);
		cRun = preheat_timer_node + 6 + ($random(seed) & 3);
		dead = 2 + ($random(seed) & 3);
		apb(1'b1, `BMS_OFS_PREHEAT_CHARGE, preheat_timer_node);
		apb(1'b1, `BMS_OFS_RUN_CHARGE, cRun);
		apb(1'b1, `BMS_OFS_DEADTIME, dead);
		apb(1'b1, `BMS_OFS_IRQ_MASK, 32'h0000_000F);
		env.supplyOn <= 1'b1;
		env.sdAbove5v0 <= 1'b1;
		repeat (20) @(posedge clk);
		chk(gnd, 1'b1, "held by shutdown");
		env.sdAbove5v0 <= 1'b0;
		waitLvl(gnd, 1'b0);
		chk({ls, hs, tclr}, 3'b100, "first pulse");
		repeat (2) @(posedge clk);
		chk(irq, 1'b1, "irq raised");
		apb(1'b0, `BMS_OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h1, "irq status");
		apb(1'b0, `BMS_OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0, "irq cleared");
		chk(irq, 1'b0, "irq low");
		onLen();
		chk(on, preheat_timer_node, "preheat low on-time");
		chk(hon, preheat_timer_node, "preheat high on-time");
		chk(off, dead, "dead time");
		$display("start test done");
		ocHigh <= 1'b1;
		repeat (100) @(posedge clk);
		ocHigh <= 1'b0;
		waitLvl(ls, 1'b0);
		base = pulseCnt;
		ocLow <= 1'b1;
		for (i = 0; pulseCnt !== 8'(base + 25) && i < 4000; i++)
			@(posedge clk);
		if (i >= 4000) stall();
		ocLow <= 1'b0;
		repeat (12) @(posedge clk);
		apb(1'b0, `BMS_OFS_STATUS, 32'h0);
		chk(rd[13:8], 6'd25, "high-side pulses ignored");
		chk(rd[2:0], BMS_PREHEAT, "no fault at limit");
		apb(1'b1, `BMS_OFS_IRQ_MASK, 32'h0);
		ocLow <= 1'b1;
		waitSt(BMS_FAULT);
		ocLow <= 1'b0;
		chk({hs, ls, gnd, tclr, irq}, 5'b00110, "fault outputs");
		apb(1'b0, `BMS_OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h4, "masked fault event");
		env.sdAbove5v0 <= 1'b1;
		repeat (20) @(posedge clk);
		waitSt(BMS_FAULT);
		env.sdAbove5v2 <= 1'b1;
		waitSt(BMS_LOCKOUT);
		$display("count test done");
		apb(1'b1, `BMS_OFS_PREHEAT_END, 32'h0000_0040);
		for (i = 0; i < 3; i++) begin
			{env.sdAbove5v0, env.sdAbove5v2} <= 2'b00;
			{env.supplyOn, env.supplyOff} <= 2'b10;
			waitSt(BMS_IGNITE);
			onLen();
			chk(on >= preheat_timer_node && on <= cRun, 1'b1, "sweep step");
			waitSt(BMS_RUN);
			onLen();
			chk(on, cRun, "run on-time");
			{env.eolHigh, env.eolLow, ocLow} <= 3'b100 >> i;
			waitSt(BMS_FAULT);
			{env.eolHigh, env.eolLow, ocLow} <= 3'b000;
			{env.supplyOn, env.supplyOff} <= 2'b01;
			waitSt(BMS_LOCKOUT);
		end
		$display("run test done");
		{env.supplyOn, env.supplyOff} <= 2'b10;
		waitSt(BMS_PREHEAT);
		env.busUnder <= 1'b1;
		waitSt(BMS_BUSTRIP);
		chk({hs, ls, pull}, 3'b001, "bus trip outputs");
		env.busUnder <= 1'b0;
		{env.supplyOn, env.supplyOff} <= 2'b01;
		waitSt(BMS_LOCKOUT);
		{env.supplyOn, env.supplyOff} <= 2'b10;
		waitSt(BMS_PREHEAT);
		{env.supplyOn, env.supplyOff} <= 2'b01;
		waitSt(BMS_LOCKOUT);
		apb(1'b0, 8'h1C, 32'h0);
		chk(errq, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped read");
		$display("trip test done");
		conclude();
	end
endmodule

// [hdl/bms_mode_sequencer.sv]
// Ballast mode sequencer: state machine, gate oscillator, APB registers
//
// Functional notes
// - Lockout: gates low, oscillator grounded, timer cleared
// - Start needs supply on and shutdown low
// - First gate pulse is low side
// - Preheat: equal alternating on-times with dead time
// - Preheat timer counts up from zero
// - Charge phase is one side's on-time, alternating
// - Discharge phase is dead time, both low
// - Preheat timer end moves to ignition
// - Ignition sweeps frequency gradually to run
// - More than 25 over-currents cause fault
// - Count over-current only during low-side on-time
// - Run: one over-current pulse causes fault
// - Fault: gates low, timer cleared, oscillator stopped
// - Run: lamp-life input out of window faults
// - Fault exits only to lockout on release
// - Bus under-voltage in preheat, ignition or run: gates low, pull supply down
// - Run uses run charge length only
`timescale 1ns/1ps
`include "bms_regs.svh"
module bms_mode_sequencer #(
	parameter int          CHG_W       = 16,
	parameter int          TMR_W       = 32,
	parameter int          OC_W        = 6,
	parameter int          OC_LIMIT    = `BMS_OC_LIMIT,
	parameter int          SWEEP_STEP  = `BMS_SWEEP_STEP_CYC,
	parameter logic [31:0] PREHEAT_END = `BMS_PREHEAT_TIME_CYC
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Comparator flags and boost request
	input  wire bms_pkg::bms_sense_t senseRaw,
	input  wire logic                boostGateReq,
	// Gate drives and analog switches
	output logic                     highSideGateOut,
	output logic                     lowSideGateOut,
	output logic                     boostGateOut,
	output logic                     oscTimingNodeGround,
	output logic                     preheatTimerNodeClear,
	output logic                     supplyPullDown,
	// Interrupt
	output logic                     irq
);
	import bms_pkg::*;

	localparam int SENSE_W = $bits(bms_sense_t);
	localparam int IRQ_W   = $bits(bms_event_t);

	////////////////////////////////////////////////////////////////////////
	// Comparator synchronisers

	logic [SENSE_W-1:0] senseSyncVec;
	bms_sense_t         sense;

	bms_sync #(
		.WIDTH(SENSE_W)
	) u_sync (
		.clk  (clk),
		.reset(reset),
		.d    (senseRaw),
		.q    (senseSyncVec)
	);

	assign sense = bms_sense_t'(senseSyncVec);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	bms_state_t       state_ff;
	bms_state_t       nxt_state;
	logic [CHG_W-1:0] preheatCharge_ff;
	logic [CHG_W-1:0] runCharge_ff;
	logic [CHG_W-1:0] deadLen_ff;
	logic [TMR_W-1:0] preheatEnd_ff;
	logic [IRQ_W-1:0] irqStat_ff;
	logic [IRQ_W-1:0] nxt_irqStat;
	logic [IRQ_W-1:0] irqMask_ff;
	logic [31:0]      prdata_ff;
	logic [CHG_W-1:0] oscCnt_ff;
	logic [CHG_W-1:0] nxt_oscCnt;
	logic             charge_ff;
	logic             nxt_charge;
	logic             highTurn_ff;
	logic             nxt_highTurn;
	logic [CHG_W-1:0] curCharge_ff;
	logic [CHG_W-1:0] nxt_curCharge;
	logic [15:0]      sweepCnt_ff;
	logic [15:0]      nxt_sweepCnt;
	logic [TMR_W-1:0] phTimer_ff;
	logic [TMR_W-1:0] nxt_phTimer;
	logic [OC_W-1:0]  ocCnt_ff;
	logic [OC_W-1:0]  nxt_ocCnt;
	logic             csPrev_ff;
	logic             highGate_ff;
	logic             lowGate_ff;
	logic             boostGate_ff;
	logic             oscGround_ff;
	logic             timerClear_ff;
	logic             pullDown_ff;
	logic             irq_ff;
	bms_event_t       events;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	wire        setupPhase  = psel && !penable;
	wire        accessPhase = psel && penable;
	wire        selPhChg    = paddr == `BMS_OFS_PREHEAT_CHARGE;
	wire        selRunChg   = paddr == `BMS_OFS_RUN_CHARGE;
	wire        selDead     = paddr == `BMS_OFS_DEADTIME;
	wire        selPhEnd    = paddr == `BMS_OFS_PREHEAT_END;
	wire        selStatus   = paddr == `BMS_OFS_STATUS;
	wire        selIrqStat  = paddr == `BMS_OFS_IRQ_STATUS;
	wire        selIrqMask  = paddr == `BMS_OFS_IRQ_MASK;
	wire        mapped      = selPhChg | selRunChg | selDead | selPhEnd |
	                          selStatus | selIrqStat | selIrqMask;
	wire        wrEn        = accessPhase && pwrite && mapped;
	wire        rdIrqClr    = accessPhase && !pwrite && selIrqStat;
	wire [31:0] statusWord  =
		(32'(state_ff) << `BMS_STAT_STATE_LSB) |
		(32'(ocCnt_ff) << `BMS_STAT_OCCNT_LSB) |
		(32'(senseSyncVec) << `BMS_STAT_SENSE_LSB);
	wire [31:0] rdMux       =
		selPhChg   ? 32'(preheatCharge_ff) :
		selRunChg  ? 32'(runCharge_ff) :
		selDead    ? 32'(deadLen_ff) :
		selPhEnd   ? 32'(preheatEnd_ff) :
		selStatus  ? statusWord :
		selIrqStat ? 32'(irqStat_ff) :
		selIrqMask ? 32'(irqMask_ff) : 32'h0000_0000;

	assign pready  = 1'b1;
	assign pslverr = accessPhase && !mapped;
	assign prdata  = prdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	always_ff @(posedge clk) begin
		if (reset) begin
			preheatCharge_ff <= CHG_W'(`BMS_PREHEAT_CHARGE_CYC);
			runCharge_ff     <= CHG_W'(`BMS_RUN_CHARGE_CYC);
			deadLen_ff       <= CHG_W'(`BMS_DEADTIME_CYC);
			preheatEnd_ff    <= TMR_W'(PREHEAT_END);
			irqMask_ff       <= `BMS_IRQ_MASK_RST;
		end else if (wrEn) begin
			if (selPhChg)
				preheatCharge_ff <= pwdata[CHG_W-1:0];
			if (selRunChg)
				runCharge_ff <= pwdata[CHG_W-1:0];
			if (selDead)
				deadLen_ff <= pwdata[CHG_W-1:0];
			if (selPhEnd)
				preheatEnd_ff <= pwdata[TMR_W-1:0];
			if (selIrqMask)
				irqMask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge clk) begin
		if (reset)
			prdata_ff <= `BMS_PRDATA_RST;
		else if (setupPhase && !pwrite)
			prdata_ff <= rdMux;
	end

	////////////////////////////////////////////////////////////////////////
	// Mode decisions

	wire running    = state_ff inside {BMS_PREHEAT, BMS_IGNITE, BMS_RUN};
	wire nxtRunning = nxt_state inside {BMS_PREHEAT, BMS_IGNITE, BMS_RUN};
	wire timing     = state_ff inside {BMS_PREHEAT, BMS_IGNITE};
	wire nxtTiming  = nxt_state inside {BMS_PREHEAT, BMS_IGNITE};
	wire phDone     = phTimer_ff >= preheatEnd_ff;
	wire sweepDone  = curCharge_ff == runCharge_ff;
	wire csRise     = sense.csOver && !csPrev_ff;
	wire ocLimit    = ocCnt_ff > OC_W'(OC_LIMIT);
	wire eolOut     = sense.eolHigh || sense.eolLow;
	wire runTrip    = state_ff == BMS_RUN && (csRise || eolOut);
	wire modeFault  = (timing && ocLimit) || runTrip;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			BMS_LOCKOUT: begin
				if (sense.supplyOn && !sense.sdAbove5v0)
					nxt_state = BMS_PREHEAT;
			end
			BMS_PREHEAT, BMS_IGNITE, BMS_RUN: begin
				if (sense.supplyOff)
					nxt_state = BMS_LOCKOUT;
				else if (sense.busUnder)
					nxt_state = BMS_BUSTRIP;
				else if (modeFault)
					nxt_state = BMS_FAULT;
				else if (state_ff == BMS_PREHEAT && phDone)
					nxt_state = BMS_IGNITE;
				else if (state_ff == BMS_IGNITE && sweepDone)
					nxt_state = BMS_RUN;
			end
			BMS_FAULT: begin
				if (sense.supplyOff || sense.sdAbove5v2)
					nxt_state = BMS_LOCKOUT;
			end
			BMS_BUSTRIP: begin
				if (sense.supplyOff)
					nxt_state = BMS_LOCKOUT;
			end
			default: begin
				nxt_state = BMS_LOCKOUT;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator: charge is on-time, discharge is dead time

	wire [CHG_W-1:0] phaseLen = charge_ff ? curCharge_ff : deadLen_ff;
	wire             phaseEnd = ({1'b0, oscCnt_ff} + 1'b1) >= {1'b0, phaseLen};

	always_comb begin
		nxt_oscCnt   = oscCnt_ff + 1'b1;
		nxt_charge   = charge_ff;
		nxt_highTurn = highTurn_ff;
		if (!running || !nxtRunning) begin
			nxt_oscCnt   = '0;
			nxt_charge   = 1'b1;
			nxt_highTurn = 1'b0;
		end else if (phaseEnd) begin
			nxt_oscCnt   = '0;
			nxt_charge   = !charge_ff;
			nxt_highTurn = charge_ff ? highTurn_ff : !highTurn_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Charge length: preheat, ignition sweep, run

	wire sweepTick = sweepCnt_ff >= 16'(SWEEP_STEP - 1);

	always_comb begin
		nxt_curCharge = preheatCharge_ff;
		nxt_sweepCnt  = '0;
		if (state_ff == BMS_RUN) begin
			nxt_curCharge = runCharge_ff;
		end else if (state_ff == BMS_IGNITE) begin
			nxt_curCharge = curCharge_ff;
			nxt_sweepCnt  = sweepTick ? 16'h0000 : sweepCnt_ff + 1'b1;
			if (sweepTick && curCharge_ff < runCharge_ff)
				nxt_curCharge = curCharge_ff + 1'b1;
			else if (sweepTick && curCharge_ff > runCharge_ff)
				nxt_curCharge = curCharge_ff - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Preheat timer and over-current counter

	wire ocEvent = timing && csRise && lowGate_ff;

	always_comb begin
		nxt_phTimer = '0;
		if (timing && nxtTiming)
			nxt_phTimer = (&phTimer_ff) ? phTimer_ff :
			              phTimer_ff + 1'b1;
		nxt_ocCnt = ocCnt_ff;
		if (state_ff == BMS_LOCKOUT)
			nxt_ocCnt = '0;
		else if (ocEvent && !ocLimit)
			nxt_ocCnt = ocCnt_ff + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Events and interrupt status

	assign events.enterPreheat = nxt_state == BMS_PREHEAT &&
	                             state_ff != BMS_PREHEAT;
	assign events.enterRun     = nxt_state == BMS_RUN &&
	                             state_ff != BMS_RUN;
	assign events.enterFault   = nxt_state == BMS_FAULT &&
	                             state_ff != BMS_FAULT;
	assign events.busTrip      = nxt_state == BMS_BUSTRIP &&
	                             state_ff != BMS_BUSTRIP;

	// Only bits shown by the read are cleared; new events win
	wire [IRQ_W-1:0] clrMask = rdIrqClr ? prdata_ff[IRQ_W-1:0] : '0;

	assign nxt_irqStat = (irqStat_ff & ~clrMask) | events;

	////////////////////////////////////////////////////////////////////////
	// State registers

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff     <= BMS_LOCKOUT;
			oscCnt_ff    <= '0;
			charge_ff    <= 1'b1;
			highTurn_ff  <= 1'b0;
			curCharge_ff <= CHG_W'(`BMS_PREHEAT_CHARGE_CYC);
			sweepCnt_ff  <= '0;
			phTimer_ff   <= '0;
			ocCnt_ff     <= '0;
			csPrev_ff    <= 1'b0;
			irqStat_ff   <= '0;
		end else begin
			state_ff     <= nxt_state;
			oscCnt_ff    <= nxt_oscCnt;
			charge_ff    <= nxt_charge;
			highTurn_ff  <= nxt_highTurn;
			curCharge_ff <= nxt_curCharge;
			sweepCnt_ff  <= nxt_sweepCnt;
			phTimer_ff   <= nxt_phTimer;
			ocCnt_ff     <= nxt_ocCnt;
			csPrev_ff    <= sense.csOver;
			irqStat_ff   <= nxt_irqStat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output drives

	wire nxtOnTime = nxtRunning && nxt_charge;

	always_ff @(posedge clk) begin
		if (reset) begin
			highGate_ff   <= 1'b0;
			lowGate_ff    <= 1'b0;
			boostGate_ff  <= 1'b0;
			oscGround_ff  <= 1'b1;
			timerClear_ff <= 1'b1;
			pullDown_ff   <= 1'b0;
			irq_ff        <= 1'b0;
		end else begin
			highGate_ff   <= nxtOnTime && nxt_highTurn;
			lowGate_ff    <= nxtOnTime && !nxt_highTurn;
			boostGate_ff  <= nxtRunning && boostGateReq;
			oscGround_ff  <= !nxtRunning;
			timerClear_ff <= !nxtTiming;
			pullDown_ff   <= nxt_state == BMS_BUSTRIP;
			irq_ff        <= |(nxt_irqStat & irqMask_ff);
		end
	end

	assign highSideGateOut       = highGate_ff;
	assign lowSideGateOut        = lowGate_ff;
	assign boostGateOut          = boostGate_ff;
	assign oscTimingNodeGround   = oscGround_ff;
	assign preheatTimerNodeClear = timerClear_ff;
	assign supplyPullDown        = pullDown_ff;
	assign irq                   = irq_ff;

endmodule

// [hdl/bms_pkg.sv]
// Types shared by the ballast mode sequencer
package bms_pkg;

	typedef enum logic [2:0] {
		BMS_LOCKOUT = 3'h0,
		BMS_PREHEAT = 3'h1,
		BMS_IGNITE  = 3'h3,
		BMS_RUN     = 3'h2,
		BMS_FAULT   = 3'h6,
		BMS_BUSTRIP = 3'h7
	} bms_state_t;

	typedef struct packed {
		logic supplyOn;
		logic supplyOff;
		logic sdAbove5v0;
		logic sdAbove5v2;
		logic eolHigh;
		logic eolLow;
		logic csOver;
		logic busUnder;
	} bms_sense_t;

	typedef struct packed {
		logic busTrip;
		logic enterFault;
		logic enterRun;
		logic enterPreheat;
	} bms_event_t;

endpackage

// [hdl/bms_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

// Clock
`define BMS_CLK_PERIOD_NS      25

// Timing figures in their own units
`define BMS_PREHEAT_CHARGE_NS  6000
`define BMS_RUN_CHARGE_NS      10000
`define BMS_DEADTIME_NS        1000
`define BMS_SWEEP_STEP_NS      2000
`define BMS_PREHEAT_TIME_MS    1000

// Timing counts in clock cycles
`define BMS_PREHEAT_CHARGE_CYC (`BMS_PREHEAT_CHARGE_NS / `BMS_CLK_PERIOD_NS)
`define BMS_RUN_CHARGE_CYC     (`BMS_RUN_CHARGE_NS / `BMS_CLK_PERIOD_NS)
`define BMS_DEADTIME_CYC       (`BMS_DEADTIME_NS / `BMS_CLK_PERIOD_NS)
`define BMS_SWEEP_STEP_CYC     (`BMS_SWEEP_STEP_NS / `BMS_CLK_PERIOD_NS)
`define BMS_PREHEAT_TIME_CYC   \
	((`BMS_PREHEAT_TIME_MS * 1000000) / `BMS_CLK_PERIOD_NS)

// Over-current events tolerated before fault
`define BMS_OC_LIMIT           25

// Register byte offsets
`define BMS_OFS_PREHEAT_CHARGE 8'h00
`define BMS_OFS_RUN_CHARGE     8'h04
`define BMS_OFS_DEADTIME       8'h08
`define BMS_OFS_PREHEAT_END    8'h0C
`define BMS_OFS_STATUS         8'h10
`define BMS_OFS_IRQ_STATUS     8'h14
`define BMS_OFS_IRQ_MASK       8'h18

// Status register field positions
`define BMS_STAT_STATE_LSB     0
`define BMS_STAT_OCCNT_LSB     8
`define BMS_STAT_SENSE_LSB     16

// Reset values
`define BMS_IRQ_MASK_RST       4'h0
`define BMS_PRDATA_RST         32'h0000_0000

`endif

// [hdl/bms_sync.sv]
// Two-flop synchroniser for comparator flags
`timescale 1ns/1ps
module bms_sync #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// Flags
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule
